// [core/gate_fault_map.svh]
// timing and reset constants of the category a fault protection block
`ifndef GATE_FAULT_MAP_SVH
`define GATE_FAULT_MAP_SVH
`define BLANK_W 8
`define SYNC_W 3
`define FLAGS_RST 3'h0
`define BLANK_CNT_RST 8'h00
`endif

// [core/gate_fault_pkg.sv]
// types of the category a fault protection block
package gate_fault_pkg;
  typedef struct packed {
    logic desaturation_sense_error_flag;
    logic overcurrent_error_flag;
    logic enable_error_flag;
  } error_flags_t;
  typedef struct packed {
    logic desaturation_sense_compare_status;
    logic overcurrent_compare_one;
    logic overcurrent_compare_two;
    logic overcurrent_level_two_sticky;
    logic enable_valid_status;
  } status_t;
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_ON = 4'h2,
    ST_PLATEAU = 4'h4,
    ST_HARD_OFF = 4'h8
  } switch_state_t;
endpackage

// [core/gate_fault_protect.sv]
// category a fault protection: desaturation, overcurrent and external enable
`timescale 1ns/10ps
`include "gate_fault_map.svh"
module gate_fault_protect #(
  parameter int BLANK_W = `BLANK_W
)(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  // pwm command and configuration
  input wire logic pwm_on_in,
  input wire logic [BLANK_W-1:0] desaturation_sense_blanking_setting_in,
  input wire logic [BLANK_W-1:0] overcurrent_blanking_setting_in,
  input wire logic [BLANK_W-1:0] two_level_turn_off_in,
  input wire logic desaturation_sense_clamp_enable_in,
  // analog comparator and enable pins
  input wire logic desaturation_sense_in,
  input wire logic overcurrent_threshold_one_in,
  input wire logic overcurrent_threshold_two_in,
  input wire logic enable_valid_in,
  // software controls
  input wire logic [2:0] flag_clear_in,
  input wire logic sticky_clear_in,
  input wire logic reactivate_in,
  // sense pin pull-down and clamp
  input wire logic desaturation_sense_pin_in,
  output logic desaturation_sense_out,
  output logic desaturation_sense_oe_out,
  // gate command and notification
  output logic gate_on_out,
  output logic safe_turn_off_out,
  output logic regular_turn_off_out,
  output logic fault_a_notify_n_out,
  output gate_fault_pkg::error_flags_t error_flags_out,
  output gate_fault_pkg::status_t status_out
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [2:0] sync_desaturation_sense_q;
  logic [2:0] sync_oc1_q;
  logic [2:0] sync_oc2_q;
  logic [2:0] sync_en_q;
  logic desaturation_sense_s_q;
  logic oc1_s_q;
  logic oc2_s_q;
  logic en_s_q;
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sync_desaturation_sense_q <= 3'h0;
      sync_oc1_q <= 3'h0;
      sync_oc2_q <= 3'h0;
      sync_en_q <= 3'h0;
      desaturation_sense_s_q <= 1'b0;
      oc1_s_q <= 1'b0;
      oc2_s_q <= 1'b0;
      en_s_q <= 1'b0;
    end
    else
    begin
      sync_desaturation_sense_q <= {sync_desaturation_sense_q[1:0], desaturation_sense_in};
      sync_oc1_q <= {sync_oc1_q[1:0], overcurrent_threshold_one_in};
      sync_oc2_q <= {sync_oc2_q[1:0], overcurrent_threshold_two_in};
      sync_en_q <= {sync_en_q[1:0], enable_valid_in};
      if (sync_desaturation_sense_q[1] == sync_desaturation_sense_q[2])
        desaturation_sense_s_q <= sync_desaturation_sense_q[2];
      if (sync_oc1_q[1] == sync_oc1_q[2])
        oc1_s_q <= sync_oc1_q[2];
      if (sync_oc2_q[1] == sync_oc2_q[2])
        oc2_s_q <= sync_oc2_q[2];
      if (sync_en_q[1] == sync_en_q[2])
        en_s_q <= sync_en_q[2];
    end
  end

  // ----------------------------------------
  // switching sequence
  // ----------------------------------------
  gate_fault_pkg::switch_state_t state_q;
  logic [BLANK_W-1:0] seq_cnt_q;
  logic [BLANK_W-1:0] db_cnt_q;
  logic [BLANK_W-1:0] oc_cnt_q;
  logic disabled_q;
  logic en_prev_q;
  logic desaturation_sense_trip;
  logic oc_trip;
  logic en_trip;
  logic any_trip;
  logic desaturation_sense_blanked;
  logic oc_blanked;
  gate_fault_pkg::error_flags_t flags_q;
  logic sticky_q;
  logic safe_q;
  logic regular_q;

  assign desaturation_sense_blanked = (db_cnt_q != `BLANK_CNT_RST);
  assign oc_blanked = (oc_cnt_q != `BLANK_CNT_RST);
  assign desaturation_sense_trip = (state_q == gate_fault_pkg::ST_ON) && !desaturation_sense_blanked && desaturation_sense_s_q;
  assign oc_trip = (state_q == gate_fault_pkg::ST_ON) && !oc_blanked && oc1_s_q;
  assign en_trip = en_prev_q && !en_s_q;
  assign any_trip = desaturation_sense_trip || oc_trip || en_trip;

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_q <= gate_fault_pkg::ST_OFF;
      seq_cnt_q <= `BLANK_CNT_RST;
    end
    else
    begin
      case (state_q)
        gate_fault_pkg::ST_OFF:
          if (pwm_on_in && !disabled_q && !any_trip)
            state_q <= gate_fault_pkg::ST_ON;
        gate_fault_pkg::ST_ON:
          if (!pwm_on_in || any_trip || disabled_q)
          begin
            state_q <= gate_fault_pkg::ST_PLATEAU;
            seq_cnt_q <= two_level_turn_off_in;
          end
        gate_fault_pkg::ST_PLATEAU:
          if (seq_cnt_q == `BLANK_CNT_RST)
            state_q <= gate_fault_pkg::ST_HARD_OFF;
          else
            seq_cnt_q <= seq_cnt_q - 1'b1;
        gate_fault_pkg::ST_HARD_OFF:
          state_q <= gate_fault_pkg::ST_OFF;
        default:
          state_q <= gate_fault_pkg::ST_OFF;
      endcase
    end
  end

  // ----------------------------------------
  // blanking counters
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      db_cnt_q <= `BLANK_CNT_RST;
    else if (state_q == gate_fault_pkg::ST_OFF && pwm_on_in && !disabled_q && !any_trip)
      db_cnt_q <= desaturation_sense_blanking_setting_in;
    else if (state_q == gate_fault_pkg::ST_HARD_OFF)
      db_cnt_q <= desaturation_sense_blanking_setting_in;
    else if (db_cnt_q != `BLANK_CNT_RST)
      db_cnt_q <= db_cnt_q - 1'b1;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      oc_cnt_q <= `BLANK_CNT_RST;
    else if (state_q == gate_fault_pkg::ST_OFF && pwm_on_in && !disabled_q && !any_trip)
      oc_cnt_q <= overcurrent_blanking_setting_in;
    else if (oc_cnt_q != `BLANK_CNT_RST)
      oc_cnt_q <= oc_cnt_q - 1'b1;
  end

  // ----------------------------------------
  // fault reaction and flags
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      en_prev_q <= 1'b0;
      disabled_q <= 1'b0;
      safe_q <= 1'b0;
      regular_q <= 1'b0;
    end
    else
    begin
      en_prev_q <= en_s_q;
      if (any_trip)
        disabled_q <= 1'b1;
      else if (reactivate_in)
        disabled_q <= 1'b0;
      safe_q <= desaturation_sense_trip || oc_trip || (safe_q && state_q != gate_fault_pkg::ST_OFF);
      regular_q <= en_trip || (regular_q && state_q != gate_fault_pkg::ST_OFF);
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      flags_q <= `FLAGS_RST;
    else
    begin
      flags_q.desaturation_sense_error_flag <= desaturation_sense_trip || (flags_q.desaturation_sense_error_flag && !flag_clear_in[2]);
      flags_q.overcurrent_error_flag <= oc_trip || (flags_q.overcurrent_error_flag && !flag_clear_in[1]);
      flags_q.enable_error_flag <= en_trip || (flags_q.enable_error_flag && !flag_clear_in[0]);
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
      sticky_q <= 1'b0;
    else
      sticky_q <= ((state_q == gate_fault_pkg::ST_ON) && !oc_blanked && oc2_s_q)
        || (sticky_q && !sticky_clear_in);
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic hold_low;
  assign hold_low = (state_q == gate_fault_pkg::ST_ON && desaturation_sense_blanked)
    || state_q == gate_fault_pkg::ST_PLATEAU || state_q == gate_fault_pkg::ST_HARD_OFF
    || (state_q == gate_fault_pkg::ST_OFF && desaturation_sense_blanked);
  assign desaturation_sense_out = 1'b0;
  assign desaturation_sense_oe_out = hold_low
    || (desaturation_sense_clamp_enable_in && state_q != gate_fault_pkg::ST_ON);
  assign gate_on_out = (state_q == gate_fault_pkg::ST_ON);
  assign safe_turn_off_out = safe_q;
  assign regular_turn_off_out = regular_q;
  assign fault_a_notify_n_out = !disabled_q;
  assign error_flags_out = flags_q;
  assign status_out.desaturation_sense_compare_status = desaturation_sense_s_q;
  assign status_out.overcurrent_compare_one = oc1_s_q && !oc_blanked;
  assign status_out.overcurrent_compare_two = oc2_s_q && !oc_blanked;
  assign status_out.overcurrent_level_two_sticky = sticky_q;
  assign status_out.enable_valid_status = en_s_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_desaturation_sense_sets_flag: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    desaturation_sense_trip |=> error_flags_out.desaturation_sense_error_flag && !fault_a_notify_n_out)
    else $error("desaturation_sense trip not flagged");
  a_oc_sets_flag: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    oc_trip |=> error_flags_out.overcurrent_error_flag && safe_turn_off_out)
    else $error("overcurrent trip not flagged");
  a_en_sets_flag: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    en_trip |=> error_flags_out.enable_error_flag && regular_turn_off_out)
    else $error("enable loss not flagged");
  a_off_no_trip: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    !gate_on_out |-> !desaturation_sense_trip && !oc_trip)
    else $error("trip while off");
  a_blank_holds: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (gate_on_out && db_cnt_q != `BLANK_CNT_RST) |-> desaturation_sense_oe_out && !desaturation_sense_trip)
    else $error("sense not held in blanking");
  a_plateau_hold: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (state_q == gate_fault_pkg::ST_PLATEAU) |-> desaturation_sense_oe_out)
    else $error("sense released in plateau");
  a_oc_blanked: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    oc_blanked |-> !status_out.overcurrent_compare_one && !status_out.overcurrent_compare_two)
    else $error("oc status not blanked");
  a_flag_sticky: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (error_flags_out.desaturation_sense_error_flag && !flag_clear_in[2]) |=> error_flags_out.desaturation_sense_error_flag)
    else $error("desaturation_sense flag dropped");
  a_stay_disabled: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (!fault_a_notify_n_out && !reactivate_in) |=> !fault_a_notify_n_out && !$rose(gate_on_out))
    else $error("left disabled state without reactivation");
  a_plateau_ends: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (state_q == gate_fault_pkg::ST_PLATEAU && seq_cnt_q == `BLANK_CNT_RST)
      |=> state_q == gate_fault_pkg::ST_HARD_OFF)
    else $error("plateau did not end");
  a_hard_off_extend: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (state_q == gate_fault_pkg::ST_HARD_OFF) |=> state_q == gate_fault_pkg::ST_OFF
      && db_cnt_q == $past(desaturation_sense_blanking_setting_in))
    else $error("hold not extended after hard turn-off");
  a_turn_on_blank: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    $rose(gate_on_out) |-> db_cnt_q == $past(desaturation_sense_blanking_setting_in)
      && oc_cnt_q == $past(overcurrent_blanking_setting_in))
    else $error("blanking not started at turn-on");
  a_clamp_off: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (desaturation_sense_clamp_enable_in && !gate_on_out) |-> desaturation_sense_oe_out)
    else $error("sense pin not clamped while off");
  a_oc_off_quiet: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    !gate_on_out |=> !$rose(error_flags_out.overcurrent_error_flag))
    else $error("overcurrent flagged while off");
  a_desaturation_sense_off_quiet: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    !gate_on_out |=> !$rose(error_flags_out.desaturation_sense_error_flag))
    else $error("desaturation_sense flagged while off");
  a_sticky_holds: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (status_out.overcurrent_level_two_sticky && !sticky_clear_in) |=> status_out.overcurrent_level_two_sticky)
    else $error("level two sticky dropped");
  a_fault_needs_trip: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    $fell(fault_a_notify_n_out) |-> $past(any_trip))
    else $error("fault output without trip");
  a_reactivate_frees: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
    (!fault_a_notify_n_out && reactivate_in && !any_trip) |=> fault_a_notify_n_out)
    else $error("reactivation ignored");
endmodule

// [dv/igbt_model.sv]
// behavioural power switch with desaturation and current sense network
`timescale 1ns/10ps
module igbt_model (
  // gate command and sense pin pull-down
  input wire logic gate_on_in,
  input wire logic sense_oe_in,
  // fault injection from the bench
  input wire logic short_in,
  input wire logic [1:0] current_level_in,
  // comparator outputs and pin level
  output logic desaturation_sense_cmp_out,
  output logic oc_one_out,
  output logic oc_two_out,
  output logic pin_out
);
  // the pull-up lifts a released pin; the comparator trips on it unless the switch is on and not shorted
  assign pin_out = ~sense_oe_in;
  assign desaturation_sense_cmp_out = pin_out & (short_in | ~gate_on_in);
  assign oc_one_out = (current_level_in != 2'h0);
  assign oc_two_out = (current_level_in == 2'h2);
endmodule

// [dv/gate_fault_protect_tb.sv]
// self-checking bench of the category a fault protection block
`timescale 1ns/10ps
module gate_fault_protect_tb;
  localparam logic [7:0] DBLANK = 8'h10;
  localparam logic [7:0] OBLANK = 8'h0c;
  localparam logic [7:0] PLATEAU = 8'h04;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic pwm_on = 1'b0;
  logic clamp_en = 1'b0;
  logic en_valid = 1'b1;
  logic [2:0] flag_clr = 3'h0;
  logic sticky_clr = 1'b0;
  logic react = 1'b0;
  logic short_sw = 1'b0;
  logic [1:0] cur_lvl = 2'h0;
  logic dsat_cmp, oc1, oc2, pin, sense_out, sense_oe, gate_on, safe_off, reg_off, fault_n;
  gate_fault_pkg::error_flags_t flags;
  gate_fault_pkg::status_t st;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;

  gate_fault_protect dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .pwm_on_in(pwm_on),
    .desaturation_sense_blanking_setting_in(DBLANK), .overcurrent_blanking_setting_in(OBLANK),
    .two_level_turn_off_in(PLATEAU), .desaturation_sense_clamp_enable_in(clamp_en), .desaturation_sense_in(dsat_cmp),
    .overcurrent_threshold_one_in(oc1), .overcurrent_threshold_two_in(oc2), .enable_valid_in(en_valid),
    .flag_clear_in(flag_clr), .sticky_clear_in(sticky_clr), .reactivate_in(react),
    .desaturation_sense_pin_in(pin), .desaturation_sense_out(sense_out),
    .desaturation_sense_oe_out(sense_oe), .gate_on_out(gate_on), .safe_turn_off_out(safe_off),
    .regular_turn_off_out(reg_off), .fault_a_notify_n_out(fault_n), .error_flags_out(flags),
    .status_out(st));
  igbt_model sw (.gate_on_in(gate_on), .sense_oe_in(sense_oe), .short_in(short_sw),
    .current_level_in(cur_lvl), .desaturation_sense_cmp_out(dsat_cmp), .oc_one_out(oc1), .oc_two_out(oc2),
    .pin_out(pin));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic wait_fault();
    int i;
    i = 0;
    while (fault_n !== 1'b0 && i < 60)
    begin
      cyc(1);
      i++;
    end
  endtask
  task automatic recover();
    pwm_on = 1'b0;
    short_sw = 1'b0;
    cur_lvl = 2'h0;
    en_valid = 1'b1;
    cyc(40);
    flag_clr = 3'h7;
    sticky_clr = 1'b1;
    react = 1'b1;
    cyc(1);
    flag_clr = 3'h0;
    sticky_clr = 1'b0;
    react = 1'b0;
    cyc(2);
    chk(fault_n, 8'h01);
    chk(flags, 8'h00);
    chk(st.overcurrent_level_two_sticky, 8'h00);
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_normal();
    pwm_on = 1'b1;
    cur_lvl = 2'h1;
    cyc(2);
    chk(gate_on, 8'h01);
    chk(sense_oe, 8'h01);
    chk(st.overcurrent_compare_one, 8'h00);
    cyc(OBLANK - 6);
    cur_lvl = 2'h0;
    cyc(DBLANK);
    chk(sense_oe, 8'h00);
    chk(fault_n, 8'h01);
    chk(st.desaturation_sense_compare_status, 8'h00);
    pwm_on = 1'b0;
    cur_lvl = 2'h2;
    cyc(60);
    chk(st.desaturation_sense_compare_status, 8'h01);
    chk(flags, 8'h00);
    chk(fault_n, 8'h01);
    chk(st.overcurrent_level_two_sticky, 8'h00);
    cur_lvl = 2'h0;
  endtask
  task automatic t_oc_trip();
    pwm_on = 1'b1;
    cyc(OBLANK + 4);
    cur_lvl = 2'h2;
    wait_fault();
    chk(flags, 8'h02);
    chk(safe_off, 8'h01);
    chk(gate_on, 8'h00);
    chk(st.overcurrent_compare_one, 8'h01);
    chk(st.overcurrent_compare_two, 8'h01);
    cyc(3);
    chk(st.overcurrent_level_two_sticky, 8'h01);
    recover();
  endtask
  task automatic t_desaturation_sense_trip();
    pwm_on = 1'b1;
    cyc(DBLANK + 4);
    short_sw = 1'b1;
    wait_fault();
    chk(flags, 8'h04);
    chk(safe_off, 8'h01);
    chk(sense_oe, 8'h01);
    cyc(PLATEAU + DBLANK);
    chk(sense_oe, 8'h01);
    cyc(4);
    chk(sense_oe, 8'h00);
    short_sw = 1'b0;
    cyc(10);
    chk(flags, 8'h04);
    chk(gate_on, 8'h00);
    recover();
  endtask
  task automatic t_enable();
    pwm_on = 1'b1;
    cyc(20);
    chk(st.enable_valid_status, 8'h01);
    en_valid = 1'b0;
    wait_fault();
    chk(flags, 8'h01);
    chk(reg_off, 8'h01);
    cyc(2);
    chk(st.enable_valid_status, 8'h00);
    recover();
  endtask
  task automatic t_clamp();
    clamp_en = 1'b1;
    cyc(60);
    chk(sense_oe, 8'h01);
    chk(sense_out, 8'h00);
    pwm_on = 1'b1;
    cyc(DBLANK + 6);
    chk(sense_oe, 8'h00);
    pwm_on = 1'b0;
    cyc(DBLANK + 30);
    chk(sense_oe, 8'h01);
    clamp_en = 1'b0;
  endtask
  task automatic t_reset();
    pwm_on = 1'b1;
    cyc(20);
    en_valid = 1'b0;
    wait_fault();
    chk(flags, 8'h01);
    resetn_in = 1'b0;
    cyc(3);
    chk(fault_n, 8'h01);
    chk(gate_on, 8'h00);
    resetn_in = 1'b1;
    en_valid = 1'b1;
    pwm_on = 1'b0;
    cyc(2);
    chk(flags, 8'h00);
    pwm_on = 1'b1;
    cyc(2);
    chk(gate_on, 8'h01);
    pwm_on = 1'b0;
  endtask

  initial
  begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  initial
  begin
    cyc(3);
    resetn_in = 1'b1;
    cyc(2);
    chk(fault_n, 8'h01);
    chk(flags, 8'h00);
    t_normal();
    t_oc_trip();
    t_desaturation_sense_trip();
    t_enable();
    t_clamp();
    t_reset();
    give_verdict();
  end
endmodule
